// ---- hw/uscw_core.sv ----
`timescale 1ns/1ps
module uscw_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bit_tick,
	input wire logic sample_tick,
	input wire logic rxd_in,
	input wire logic cts_change,
	input wire logic break_seen,
	input wire logic sleep_req,
	output logic txd_out,
	output logic txd_oe,
	output logic osc_wake,
	output logic core_clk_en,
	output logic cpu_wake,
	output logic irq,
	output logic dma_rx_req,
	output logic dma_tx_req
);
	logic [31:0] control_a;
	logic [31:0] control_b;
	logic [7:0] int_en;
	logic [7:0] int_flag;
	logic collision_status;
	logic [2:0] sync_busy;
	logic [3:0] sync_cnt;
	logic [8:0] tx_buf;
	logic tx_full;
	logic [8:0] rx_buf;
	logic rx_full;
	logic [9:0] tx_shift;
	logic [3:0] tx_bits;
	uscw_pkg::uscw_tx_state_t tx_state;
	logic tx_bit;
	logic rx_prev;
	logic [4:0] samp_idx;
	logic [2:0] votes;
	logic voted;
	logic rx_active;
	logic [3:0] rx_bits;
	logic [9:0] rx_shift;
	logic frame_hold;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic do_write;
	logic write_err;
	logic collision;
	logic loopback;
	logic rx_line;
	logic rx_fall;
	logic clk_on;
	logic rx_done;
	logic [4:0] mid;
	logic [4:0] last;
	logic sync_op;
	logic control_b_wr;
	logic control_a_wr;
	logic data_rd;
	logic data_wr;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign control_a_wr = do_write && aw_addr == uscw_pkg::control_a_addr;
	assign control_b_wr = do_write && aw_addr == uscw_pkg::control_b_addr;
	assign data_wr = do_write && aw_addr == uscw_pkg::data_addr && !tx_full;
	assign data_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == uscw_pkg::data_addr;
	// busy check: any control a or control b write overlapping that register's pending sync
	assign sync_op = control_a_wr || (control_b_wr && (w_data[uscw_pkg::control_b_transmitter_enable_bit]
		!= control_b[uscw_pkg::control_b_transmitter_enable_bit] || w_data[uscw_pkg::control_b_receiver_enable_bit]
		!= control_b[uscw_pkg::control_b_receiver_enable_bit]));
	assign write_err = (control_a_wr && (sync_busy[uscw_pkg::sb_enable]
		|| sync_busy[uscw_pkg::sb_software_reset])) || (control_b_wr && sync_busy[uscw_pkg::sb_control_b]);

	// address and data may arrive in either order; hold each until both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response; slverr on busy violation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= uscw_pkg::resp_okay;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_err ? uscw_pkg::resp_slverr : uscw_pkg::resp_okay;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read data; unmapped words read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= uscw_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= uscw_pkg::resp_okay;
			case (s_axi_araddr)
				uscw_pkg::control_a_addr: s_axi_rdata <= control_a;
				uscw_pkg::control_b_addr: s_axi_rdata <= control_b;
				uscw_pkg::interrupt_enable_clear_addr: s_axi_rdata <= {24'h000000, int_en};
				uscw_pkg::interrupt_flags_addr: s_axi_rdata <= {24'h000000, int_flag};
				uscw_pkg::status_addr: s_axi_rdata <= 32'(collision_status) << uscw_pkg::status_collision_status_bit;
				uscw_pkg::sync_busy_bits_addr: s_axi_rdata <= {29'h0, sync_busy};
				uscw_pkg::data_addr: s_axi_rdata <= {23'h0, rx_buf};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// control registers; collision clears transmitter enable by hardware
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_a <= 32'h0000_0000;
			control_b <= 32'h0000_0000;
		end else begin
			if (control_a_wr && !write_err) begin
				control_a <= w_data;
			end else if (sync_busy[uscw_pkg::sb_software_reset] && sync_cnt == 4'h1) begin
				control_a <= 32'h0000_0000;
			end
			if (control_b_wr && !write_err) begin
				control_b <= w_data;
			end
			if (collision) begin
				control_b[uscw_pkg::control_b_transmitter_enable_bit] <= 1'b0;
			end
			if (control_a[uscw_pkg::control_a_software_reset_bit] && sync_cnt == 4'h1) begin
				control_b <= 32'h0000_0000;
			end
		end
	end

	// sync busy: set at once, cleared after the crossing time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_busy <= 3'b000;
			sync_cnt <= 4'h0;
		end else if (collision || (sync_op && !write_err)) begin
			sync_cnt <= uscw_pkg::sync_count;
			if (collision || control_b_wr) begin
				sync_busy[uscw_pkg::sb_control_b] <= 1'b1;
			end
			if (control_a_wr) begin
				sync_busy[uscw_pkg::sb_software_reset] <= w_data[uscw_pkg::control_a_software_reset_bit];
				sync_busy[uscw_pkg::sb_enable] <= 1'b1;
			end
		end else if (sync_cnt != 4'h0) begin
			sync_cnt <= sync_cnt - 4'h1;
			if (sync_cnt == 4'h1) begin
				sync_busy <= 3'b000;
			end
		end
	end

	// interrupt enables via set and clear registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_en <= 8'h00;
		end else if (do_write && aw_addr == uscw_pkg::interrupt_enable_set_addr) begin
			int_en <= int_en | w_data[7:0];
		end else if (do_write && aw_addr == uscw_pkg::interrupt_enable_clear_addr) begin
			int_en <= int_en & ~w_data[7:0];
		end
	end

	// loop-back when both pinouts select the same pad
	assign loopback = control_a[uscw_pkg::control_a_receive_pinout_select_lo +: 2] == control_a[uscw_pkg::control_a_transmit_pinout_select_lo +: 2];
	// loop-back goes through the pad, so a remote node pulling the line is still seen
	assign rx_line = loopback ? (rxd_in & (txd_oe ? txd_out : 1'b1)) : rxd_in;
	assign rx_fall = rx_prev && !rx_line;
	// 16x or 8x oversampling selects the voting window
	assign mid = control_a[uscw_pkg::control_a_sampr_lo] ? uscw_pkg::os8_mid : uscw_pkg::os16_mid;
	assign last = control_a[uscw_pkg::control_a_sampr_lo] ? uscw_pkg::os8_last : uscw_pkg::os16_last;
	assign voted = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
	// frame ends at the last sample of the stop bit, bit nine counted from zero
	assign rx_done = rx_active && sample_tick && samp_idx == last
		&& rx_bits == uscw_pkg::frame_bits - 4'h1;
	assign tx_bit = tx_shift[0];
	// gated by enables; compare at detection point; only while sending
	assign collision = control_b[uscw_pkg::control_b_collision_detect_enable_bit] && control_b[uscw_pkg::control_b_receiver_enable_bit]
		&& control_b[uscw_pkg::control_b_transmitter_enable_bit] && tx_state == uscw_pkg::uscw_tx_shift && rx_active
		&& sample_tick && samp_idx == mid + 5'h02 && voted != tx_bit;

	// receiver sampling; sample 0 begins at the start edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_prev <= 1'b1;
			rx_active <= 1'b0;
			samp_idx <= 5'h00;
			votes <= 3'b111;
			rx_bits <= 4'h0;
			rx_shift <= 10'h000;
		end else begin
			rx_prev <= rx_line;
			if (!rx_active) begin
				// reception dropped while the clock is stopped
				if (rx_fall && control_b[uscw_pkg::control_b_receiver_enable_bit] && clk_on) begin
					rx_active <= 1'b1;
					samp_idx <= 5'h00;
					rx_bits <= 4'h0;
				end
			end else if (sample_tick) begin
				samp_idx <= samp_idx == last ? 5'h00 : samp_idx + 5'h01;
				if (samp_idx >= mid - 5'h01 && samp_idx <= mid + 5'h01) begin
					votes <= {votes[1:0], rx_line};
				end
				if (samp_idx == last) begin
					rx_shift <= {voted, rx_shift[9:1]};
					rx_bits <= rx_bits + 4'h1;
					if (rx_bits == uscw_pkg::frame_bits - 4'h1) begin
						rx_active <= 1'b0;
					end
				end
			end
		end
	end

	// receive holding register; dma request until data is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_buf <= 9'h000;
			rx_full <= 1'b0;
		end else if (rx_done) begin
			rx_buf <= {1'b0, rx_shift[9:2]};
			rx_full <= 1'b1;
		end else if (data_rd) begin
			rx_full <= 1'b0;
		end
	end
	assign dma_rx_req = rx_full;

	// transmit buffer and shifter; collision flushes and aborts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buf <= 9'h000;
			tx_full <= 1'b0;
			tx_state <= uscw_pkg::uscw_tx_idle;
			tx_shift <= 10'h3FF;
			tx_bits <= 4'h0;
		end else if (collision) begin
			tx_full <= 1'b0;
			tx_state <= uscw_pkg::uscw_tx_idle;
			tx_shift <= 10'h3FF;
		end else begin
			if (data_wr) begin
				tx_buf <= w_data[8:0];
				tx_full <= 1'b1;
			end
			case (tx_state)
				uscw_pkg::uscw_tx_idle: begin
					if (tx_full && control_b[uscw_pkg::control_b_transmitter_enable_bit] && bit_tick) begin
						tx_shift <= {1'b1, tx_buf[7:0], 1'b0};
						tx_full <= 1'b0;
						tx_bits <= 4'h0;
						tx_state <= uscw_pkg::uscw_tx_shift;
					end
				end
				uscw_pkg::uscw_tx_shift: begin
					if (bit_tick) begin
						tx_shift <= {1'b1, tx_shift[9:1]};
						tx_bits <= tx_bits + 4'h1;
						if (tx_bits == uscw_pkg::frame_bits - 4'h1) begin
							tx_state <= uscw_pkg::uscw_tx_idle;
						end
					end
				end
				default: tx_state <= uscw_pkg::uscw_tx_idle;
			endcase
		end
	end
	assign dma_tx_req = !tx_full && control_b[uscw_pkg::control_b_transmitter_enable_bit];
	// pin released once the transmitter is disabled
	assign txd_oe = control_b[uscw_pkg::control_b_transmitter_enable_bit];
	assign txd_out = tx_bit;

	// collision status and flags; hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			collision_status <= 1'b0;
			int_flag <= 8'h00;
		end else begin
			collision_status <= collision || (collision_status && !(do_write && aw_addr == uscw_pkg::status_addr
				&& w_data[uscw_pkg::status_collision_status_bit]));
			if (do_write && aw_addr == uscw_pkg::interrupt_flags_addr) begin
				int_flag <= int_flag & ~w_data[7:0];
			end
			if (collision) begin
				int_flag[uscw_pkg::irq_error] <= 1'b1;
				int_flag[uscw_pkg::irq_txc] <= 1'b1;
			end
			if (tx_state == uscw_pkg::uscw_tx_shift && bit_tick
				&& tx_bits == uscw_pkg::frame_bits - 4'h1
				&& !tx_full) begin
				int_flag[uscw_pkg::irq_txc] <= 1'b1;
			end
			// start bit raises receive start at once
			if (rx_fall && !rx_active && control_b[uscw_pkg::control_b_receiver_enable_bit] && clk_on) begin
				int_flag[uscw_pkg::irq_rxs] <= 1'b1;
			end
			if (rx_done) begin
				int_flag[uscw_pkg::irq_rxc] <= 1'b1;
			end
			if (cts_change) begin
				int_flag[uscw_pkg::irq_clear_to_send_change_flag] <= 1'b1;
			end
			if (break_seen) begin
				int_flag[uscw_pkg::irq_break_received_flag] <= 1'b1;
			end
			// data register empty is a level from the buffer
			int_flag[uscw_pkg::irq_dre] <= !tx_full;
		end
	end

	// one request line for all enabled flags
	assign irq = |(int_flag & int_en);

	// frame hold keeps clocks alive from a detected start to the frame end only if reception began; otherwise it lasts one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_hold <= 1'b0;
		end else if (rx_fall && control_b[uscw_pkg::control_b_start_of_frame_detect_enable_bit]) begin
			frame_hold <= 1'b1;
		end else if (!rx_active && !rx_fall) begin
			frame_hold <= 1'b0;
		end
	end

	// run-in-standby keeps clock; otherwise stop after transfers end
	assign clk_on = !sleep_req || control_a[uscw_pkg::control_a_run_in_standby_bit] || frame_hold
		|| rx_active || tx_state == uscw_pkg::uscw_tx_shift;
	// falling rx edge wakes oscillator and core clock in either mode
	assign osc_wake = (control_b[uscw_pkg::control_b_start_of_frame_detect_enable_bit] && !rx_line && rx_prev) || frame_hold;
	assign core_clk_en = clk_on || osc_wake;
	// wake is combinational, needs no running clock
	assign cpu_wake = irq;
endmodule

// ---- hw/uscw_pkg.sv ----
package uscw_pkg;
	localparam logic [7:0] control_a_addr = 8'h00;
	localparam logic [7:0] control_b_addr = 8'h04;
	localparam logic [7:0] interrupt_enable_clear_addr = 8'h14;
	localparam logic [7:0] interrupt_enable_set_addr = 8'h16;
	localparam logic [7:0] interrupt_flags_addr = 8'h18;
	localparam logic [7:0] status_addr = 8'h1A;
	localparam logic [7:0] sync_busy_bits_addr = 8'h1C;
	localparam logic [7:0] data_addr = 8'h28;
	localparam logic [7:0] sleep_addr = 8'h34;
	// control a fields
	localparam int control_a_software_reset_bit = 0;
	localparam int control_a_enable_bit = 1;
	localparam int control_a_run_in_standby_bit = 7;
	localparam int control_a_transmit_pinout_select_lo = 16;
	localparam int control_a_receive_pinout_select_lo = 20;
	localparam int control_a_sample_adjust_lo = 22;
	localparam int control_a_sampr_lo = 13;
	localparam int control_a_communication_mode_bit = 28;
	// control b fields
	localparam int control_b_collision_detect_enable_bit = 8;
	localparam int control_b_start_of_frame_detect_enable_bit = 9;
	localparam int control_b_transmitter_enable_bit = 16;
	localparam int control_b_receiver_enable_bit = 17;
	// interrupt flag and status bit positions
	localparam int irq_dre = 0;
	localparam int irq_txc = 1;
	localparam int irq_rxc = 2;
	localparam int irq_rxs = 3;
	localparam int irq_clear_to_send_change_flag = 4;
	localparam int irq_break_received_flag = 5;
	localparam int irq_error = 7;
	localparam int status_collision_status_bit = 5;
	// sync busy positions
	localparam int sb_software_reset = 0;
	localparam int sb_enable = 1;
	localparam int sb_control_b = 2;
	// timing, bus responses and transmit states
	localparam int clk_mhz = 40;
	localparam int sync_ns = 100;
	localparam int sync_cycles = (sync_ns * clk_mhz + 999) / 1000;
	localparam logic [3:0] sync_count = 4'(sync_cycles);
	localparam logic [4:0] os16_mid = 5'h08;
	localparam logic [4:0] os8_mid = 5'h04;
	localparam logic [4:0] os16_last = 5'h0F;
	localparam logic [4:0] os8_last = 5'h07;
	localparam logic [3:0] frame_bits = 4'hA;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [1:0] {uscw_tx_idle, uscw_tx_shift} uscw_tx_state_t;
endpackage

// ---- tb/uscw_checker.sv ----
`timescale 1ns/1ps
module uscw_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rxd_in,
	input wire logic sleep_req,
	input wire logic osc_wake,
	input wire logic core_clk_en,
	input wire logic cpu_wake,
	input wire logic irq,
	input wire logic dma_rx_req,
	input wire logic dma_tx_req
);
	logic aw_hs, w_hs, ar_hs, start_of_frame_detect_enable_q;
	// handshakes on the register bus
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	// start-of-frame enable as last written; refused writes would fool it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_of_frame_detect_enable_q <= 1'b0;
		end else if (aw_hs && w_hs && s_axi_awaddr == uscw_pkg::control_b_addr) begin
			start_of_frame_detect_enable_q <= s_axi_wdata[uscw_pkg::control_b_start_of_frame_detect_enable_bit];
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_wake_irq: assert property (cpu_wake == irq)
		else $error("cpu wake differs from irq");
	a_clock_awake: assert property (!sleep_req |-> core_clk_en)
		else $error("core clock off while awake");
	a_tx_dma_drop: assert property (aw_hs && w_hs && s_axi_awaddr == uscw_pkg::data_addr
		|-> ##2 !dma_tx_req)
		else $error("tx dma request stays after data write");
	a_rx_dma_drop: assert property (ar_hs && s_axi_araddr == uscw_pkg::data_addr
		|-> ##[1:2] !dma_rx_req)
		else $error("rx dma request stays after data read");
	a_irq_held: assert property (irq && !(aw_hs || w_hs) && !$past(aw_hs || w_hs)
		&& !$past(aw_hs || w_hs, 2) |=> irq)
		else $error("irq dropped without clear");
	a_osc_start: assert property (start_of_frame_detect_enable_q && $fell(rxd_in) |-> ##[0:2] osc_wake)
		else $error("oscillator not woken by start bit");
	a_write_answer: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read response late");
	cover property ($rose(irq));
	cover property ($rose(osc_wake));
	cover property ($rose(dma_rx_req));
endmodule

bind uscw_core uscw_checker uscw_checker_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rxd_in, .sleep_req, .osc_wake,
	.core_clk_en, .cpu_wake, .irq, .dma_rx_req, .dma_tx_req);

// ---- tb/uscw_node.sv ----
`timescale 1ns/1ps
module uscw_node (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bit_tick,
	input wire logic send,
	input wire logic [7:0] byte_in,
	input wire logic jam,
	output logic line
);
	logic [8:0] shift;
	logic [3:0] left;
	logic send_p, jam_p;
	// requests wait for a bit boundary; released line reads high through the pull-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{shift, left, send_p, jam_p} <= '0;
			line <= 1'b1;
		end else begin
			if (send) send_p <= 1'b1;
			if (jam) jam_p <= 1'b1;
			if (bit_tick) begin
				if (left != 4'h0) begin
					line <= shift[0];
					shift <= {1'b1, shift[8:1]};
					left <= left - 4'h1;
				end else if (send_p) begin
					line <= 1'b0; // start bit, data lsb first, one stop bit
					shift <= {1'b1, byte_in};
					left <= 4'h9;
					send_p <= 1'b0;
				end else if (jam_p) begin
					line <= 1'b0;
					jam_p <= 1'b0;
				end else begin
					line <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- tb/usart_collision_wake_irq_sync_bench.sv ----
`timescale 1ns/1ps
module usart_collision_wake_irq_sync_bench;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, b;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic bit_tick, sample_tick, rxd_in, cts_change, break_seen, sleep_req, send, jam, node_line;
	logic txd_out, txd_oe, osc_wake, core_clk_en, cpu_wake, irq, dma_rx_req, dma_tx_req;
	logic [7:0] node_byte;
	logic [4:0] cyc;
	int n_errors = 0;
	int check_count = 0;
	always #12.5 aclk = ~aclk;
	// shared pad: open drain with pull-up, device drives only while enabled
	assign rxd_in = (txd_oe ? txd_out : 1'b1) & node_line;
	// 16 samples per bit, one bit every 32 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 5'h01;
		sample_tick <= cyc[0];
		bit_tick <= (cyc == 5'h1F);
	end
	uscw_core uscw_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick, .sample_tick, .rxd_in,
		.cts_change, .break_seen, .sleep_req, .txd_out, .txd_oe, .osc_wake, .core_clk_en,
		.cpu_wake, .irq, .dma_rx_req, .dma_tx_req);
	uscw_node uscw_node_i (.aclk, .aresetn, .bit_tick, .send, .byte_in(node_byte), .jam,
		.line(node_line));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic guard(input int n);
		if (n > 60) begin
			check("wait done", 32'h0, 32'h1);
			finish_test();
		end
	endtask
	// bready stays high, so the response is taken where bvalid is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic [2:0] hs;
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid} <= 2'b11;
		forever begin
			@(negedge aclk);
			hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
			r = s_axi_bresp;
			@(posedge aclk);
			if (hs[2]) s_axi_awvalid <= 1'b0;
			if (hs[1]) s_axi_wvalid <= 1'b0;
			if (hs[0]) break;
			guard(++n);
		end
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] hs;
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(negedge aclk);
			hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
			d = s_axi_rdata;
			@(posedge aclk);
			if (hs[1]) s_axi_arvalid <= 1'b0;
			if (hs[0]) break;
			guard(++n);
		end
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] want);
		logic [31:0] v;
		for (int n = 0; n < 400; n++) begin
			rd_reg(a, v);
			if ((v & mask) === want) return;
		end
		check("poll", v & mask, want);
		finish_test();
	endtask
	function automatic logic [31:0] control_b_on();
		return (32'h1 << uscw_pkg::control_b_transmitter_enable_bit) | (32'h1 << uscw_pkg::control_b_receiver_enable_bit)
			| (32'h1 << uscw_pkg::control_b_collision_detect_enable_bit) | (32'h1 << uscw_pkg::control_b_start_of_frame_detect_enable_bit);
	endfunction
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, node_byte} = '0;
		s_axi_wstrb = 4'hF;
		{cts_change, break_seen, sleep_req, send, jam, cyc, sample_tick, bit_tick} = '0;
		void'($urandom(32'h4481));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("reset pins", {irq, dma_rx_req, dma_tx_req, txd_oe, txd_out}, 5'h01);
		rd_reg(uscw_pkg::sync_busy_bits_addr, rd);
		check("sync_busy_bits", rd, 32'h0);
		rd_reg(8'h40, rd);
		check("unmapped", rd, 32'h0);
		$display("reset test done");
		wr(uscw_pkg::control_a_addr, 32'h82, resp);
		check("enable resp", resp, uscw_pkg::resp_okay);
		wr(uscw_pkg::control_a_addr, 32'h82, resp);
		check("busy resp", resp, uscw_pkg::resp_slverr);
		poll(uscw_pkg::sync_busy_bits_addr, 32'h7, 32'h0);
		wr(uscw_pkg::control_b_addr, control_b_on(), resp);
		rd_reg(uscw_pkg::sync_busy_bits_addr, rd);
		check("control_b busy", rd & 32'h4, 32'h4);
		poll(uscw_pkg::sync_busy_bits_addr, 32'h7, 32'h0);
		wr(uscw_pkg::interrupt_enable_set_addr, 32'h86, resp);
		check("tx ready", {txd_oe, dma_tx_req, irq}, 3'b110);
		$display("sync test done");
		repeat (3) begin
			b = 8'($urandom());
			wr(uscw_pkg::data_addr, {24'h0, b}, resp);
			poll(uscw_pkg::interrupt_flags_addr, 32'h4, 32'h4);
			check("irq on rxc", irq, 1'b1);
			rd_reg(uscw_pkg::data_addr, rd);
			check("loop data", rd[7:0], b);
			check("rx dma", dma_rx_req, 1'b0);
			poll(uscw_pkg::interrupt_flags_addr, 32'h2, 32'h2);
			wr(uscw_pkg::interrupt_flags_addr, 32'hFF, resp);
			check("irq cleared", irq, 1'b0);
		end
		$display("loopback test done");
		for (int i = 4; i < 6; i++) begin
			cts_change <= (i == 4);
			break_seen <= (i == 5);
			@(posedge aclk);
			{cts_change, break_seen} <= 2'b00;
			wr(uscw_pkg::interrupt_enable_set_addr, 32'h1 << i, resp);
			check("irq enabled", irq, 1'b1);
			wr(uscw_pkg::interrupt_enable_clear_addr, 32'h1 << i, resp);
			check("irq disabled", irq, 1'b0);
			rd_reg(uscw_pkg::interrupt_flags_addr, rd);
			check("flag kept", rd[i], 1'b1);
		end
		wr(uscw_pkg::interrupt_flags_addr, 32'hFF, resp);
		$display("interrupt test done");
		node_byte <= 8'($urandom());
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		poll(uscw_pkg::interrupt_flags_addr, 32'h4, 32'h4);
		rd_reg(uscw_pkg::data_addr, rd);
		check("node data", rd[7:0], node_byte);
		rd_reg(uscw_pkg::interrupt_flags_addr, rd);
		check("start flag", rd[uscw_pkg::irq_rxs], 1'b1);
		rd_reg(uscw_pkg::status_addr, rd);
		check("no collision", rd[uscw_pkg::status_collision_status_bit], 1'b0);
		wr(uscw_pkg::interrupt_flags_addr, 32'hFF, resp);
		$display("idle receive test done");
		wr(uscw_pkg::data_addr, 32'hFF, resp);
		for (int n = 0; txd_out !== 1'b0; n++) begin
			@(negedge aclk);
			guard(n / 8);
		end
		@(posedge aclk);
		jam <= 1'b1;
		@(posedge aclk);
		jam <= 1'b0;
		poll(uscw_pkg::status_addr, 32'h20, 32'h20);
		check("pin released", txd_oe, 1'b0);
		rd_reg(uscw_pkg::interrupt_flags_addr, rd);
		check("error and txc", rd & 32'h82, 32'h82);
		poll(uscw_pkg::sync_busy_bits_addr, 32'h4, 32'h0);
		wr(uscw_pkg::control_b_addr, control_b_on(), resp);
		poll(uscw_pkg::sync_busy_bits_addr, 32'h4, 32'h0);
		check("tx back", txd_oe, 1'b1);
		$display("collision test done");
		sleep_req <= 1'b1;
		repeat (2) @(posedge aclk);
		check("clock in sleep", core_clk_en, 1'b1);
		sleep_req <= 1'b0;
		$display("sleep test done");
		finish_test();
	end
endmodule
